// ===== hw/imc_master.sv
// Command/status front end and byte sequencer of the I2C master
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module imc_master
    import imc_pkg::*;
#(
    parameter int QTR_CYC = QTR_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Clock line, open drain
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    // Data line, open drain
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Operation finished or aborted
    output logic op_done
);
    // ==========================================
    // Declarations
    imc_state_t state; // Controller state
    imc_state_t next_state; // Its next value
    logic scl_s; // Synchronised SCL
    logic sda_s; // Synchronised SDA
    logic line_busy; // START seen, no STOP yet
    logic [7:0] target; // Address and direction
    logic [7:0] data_reg; // Data to send or received
    logic rx_mode; // Operation receives
    logic stop_req; // STOP after the byte
    logic ack_req; // Acknowledge received byte
    logic arb_lost; // Arbitration lost
    logic data_nack; // Data not acknowledged
    logic addr_nack; // Address not acknowledged
    logic err; // Any of the three
    logic [11:0] div_cnt; // Quarter divider
    logic [1:0] qtr; // Quarter within a bit
    logic [3:0] bit_idx; // Bit within a slot
    logic [9:0] shift_tx; // Bits to place, 1 = release
    logic [7:0] shift_rx; // Bits sampled
    logic slot_nack; // Ack slot read high
    logic next_scl_oe; // Next SCL drive
    logic next_sda_oe; // Next SDA drive
    imc_cmd_t wr_cmd; // Command field of a write
    imc_action_t act; // Its decoded action
    imc_status_t status; // Status field
    logic [31:0] rd_val; // Selected read value
    logic cmd_wr; // Write to command register
    logic go; // Accepted command from idle
    logic halt; // STOP command while holding
    logic active; // Bus sequence running
    logic div_end; // Divider at last count
    logic stretch; // Slave holds SCL low
    logic qtick; // One quarter elapsed
    logic qend; // Last quarter elapsed
    logic slot; // In an address or data slot
    logic sample; // Sample point of a bit
    logic shift; // Present the next bit
    logic last_bit; // Acknowledge bit
    logic tx_mode; // Slot drives data
    logic arb_hit; // Released bit read low
    logic slot_end; // Slot complete
    logic load_addr; // Enter address slot
    logic load_data; // Enter data slot

    // ==========================================
    // Bus line synchronisers and START/STOP watcher
    imc_line_mon u_mon (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .scl_s(scl_s),
        .sda_s(sda_s),
        .line_busy(line_busy)
    );

    // ==========================================
    // Command decoding from the idle state
    function automatic imc_action_t decode_idle(input logic rs, input imc_cmd_t c);
        imc_action_t a;
        a = ACT_NOP;
        // Start and run together begin an operation, except a receive that sets both ack and stop
        if (c.run && c.start) begin
            if (!rs) begin
                a = c.stop ? ACT_TX_STOP : ACT_TX;
            end else if (!(c.ack && c.stop)) begin
                a = c.stop ? ACT_RX_STOP : ACT_RX;
            end
        end
        return a;
    endfunction

    // Write decode
    assign cmd_wr = reg_wr && (reg_addr == OFF_CMDSTAT);
    assign wr_cmd = imc_cmd_t'(reg_wdata[3:0]);
    // Direction comes from the target register
    assign act = decode_idle(target[0], wr_cmd);
    // Anything else in idle is ignored
    assign go = cmd_wr && (state == S_IDLE) && (act != ACT_NOP);
    // Plain STOP while the bus is held
    assign halt = cmd_wr && (state == S_HOLD) && wr_cmd.stop
        && !wr_cmd.start && !wr_cmd.run;

    // ==========================================
    // Quarter-bit timing
    assign active = (state != S_IDLE) && (state != S_HOLD);
    assign slot = (state == S_ADDR) || (state == S_DATA);
    assign div_end = div_cnt == 12'(QTR_CYC - 1);
    // Released SCL still low means the slave stretches the clock
    assign stretch = slot && !scl_oe && !scl_s;
    assign qtick = active && div_end && !stretch;
    assign qend = qtick && (qtr == 2'h3);

    // Divider restarts whenever a sequence starts
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 12'h000;
        end else if (!active || qtick) begin
            div_cnt <= 12'h000;
        end else if (!div_end) begin
            div_cnt <= div_cnt + 12'h001;
        end
    end

    // Quarter counter wraps every bit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            qtr <= 2'h0;
        end else if (!active) begin
            qtr <= 2'h0;
        end else if (qtick) begin
            qtr <= qtr + 2'h1;
        end
    end

    // ==========================================
    // Slot control
    assign last_bit = bit_idx == SLOT_LAST;
    assign sample = slot && qtick && (qtr == 2'h2);
    assign shift = slot && qtick && (qtr == 2'h0);
    assign tx_mode = (state == S_ADDR) || !rx_mode;
    // A released bit that reads low means another master won
    assign arb_hit = sample && tx_mode && !last_bit && shift_tx[9] && !sda_s;
    assign slot_end = slot && qend && last_bit;
    assign load_addr = (state == S_START) && qend;
    assign load_data = (state == S_ADDR) && slot_end && !slot_nack;

    // Shifters; a leading zero keeps SDA low for the first quarter
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_tx <= 10'h000;
        end else if (load_addr) begin
            shift_tx <= {1'b0, target, 1'b1};
        end else if (load_data && rx_mode) begin
            shift_tx <= {1'b0, 8'hff, !ack_req};
        end else if (load_data) begin
            shift_tx <= {1'b0, data_reg, 1'b1};
        end else if (shift) begin
            shift_tx <= {shift_tx[8:0], 1'b1};
        end
    end

    // Bit index counts nine bits per slot
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_idx <= 4'h0;
        end else if (load_addr || load_data) begin
            bit_idx <= 4'h0;
        end else if (slot && qend) begin
            bit_idx <= bit_idx + 4'h1;
        end
    end

    // Sampling of data bits and the acknowledge bit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_rx <= 8'h00;
            slot_nack <= 1'b0;
        end else if (sample && last_bit) begin
            slot_nack <= sda_s;
        end else if (sample) begin
            shift_rx <= {shift_rx[6:0], sda_s};
        end
    end

    // ==========================================
    // State machine
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (go) begin
                    next_state = S_START;
                end
            end
            S_START: begin
                if (qend) begin
                    next_state = S_ADDR;
                end
            end
            S_ADDR: begin
                if (arb_hit) begin
                    next_state = S_IDLE;
                end else if (slot_end) begin
                    next_state = slot_nack ? S_STOP : S_DATA;
                end
            end
            S_DATA: begin
                if (arb_hit) begin
                    next_state = S_IDLE;
                end else if (slot_end && (stop_req || (slot_nack && !rx_mode))) begin
                    next_state = S_STOP;
                end else if (slot_end) begin
                    next_state = S_HOLD;
                end
            end
            S_HOLD: begin
                if (halt) begin
                    next_state = S_STOP;
                end
            end
            S_STOP: begin
                if (qend) begin
                    next_state = S_IDLE;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================
    // Line drive per state and quarter
    always_comb begin
        next_scl_oe = 1'b0;
        next_sda_oe = 1'b0;
        case (state)
            // SDA falls while SCL is high
            S_START: begin
                next_sda_oe = qtr[1];
            end
            // SCL low in the first half of each bit
            S_ADDR, S_DATA: begin
                next_scl_oe = !qtr[1];
                next_sda_oe = !shift_tx[9];
            end
            // Bus kept by holding SCL low
            S_HOLD: begin
                next_scl_oe = 1'b1;
            end
            // SDA rises while SCL is high
            S_STOP: begin
                next_scl_oe = qtr == 2'h0;
                next_sda_oe = !qtr[1];
            end
            default: begin
                next_scl_oe = 1'b0;
            end
        endcase
    end

    // Pin registers; the lines are only ever pulled low
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            scl_oe <= next_scl_oe;
            sda_oe <= next_sda_oe;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

    // ==========================================
    // Software registers and result flags
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            target <= RST_TARGET;
            data_reg <= RST_DATA;
        end else begin
            if (reg_wr && (reg_addr == OFF_TARGET)) begin
                target <= reg_wdata[7:0];
            end
            // Received byte lands in the data register
            if (reg_wr && (reg_addr == OFF_DATA)) begin
                data_reg <= reg_wdata[7:0];
            end else if ((state == S_DATA) && slot_end && rx_mode) begin
                data_reg <= shift_rx;
            end
        end
    end

    // Command latch; loaded only when a command is accepted from idle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_mode <= 1'b0;
            stop_req <= 1'b0;
            ack_req <= 1'b0;
        end else if (go) begin
            rx_mode <= (act == ACT_RX) || (act == ACT_RX_STOP);
            stop_req <= (act == ACT_TX_STOP) || (act == ACT_RX_STOP);
            ack_req <= wr_cmd.ack;
        end
    end

    // Flags clear when an operation starts, set on each failure
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            arb_lost <= 1'b0;
            addr_nack <= 1'b0;
            data_nack <= 1'b0;
            err <= 1'b0;
        end else if (go) begin
            arb_lost <= 1'b0;
            addr_nack <= 1'b0;
            data_nack <= 1'b0;
            err <= 1'b0;
        end else if (arb_hit) begin
            arb_lost <= 1'b1;
            err <= 1'b1;
        end else if ((state == S_ADDR) && slot_end && slot_nack) begin
            addr_nack <= 1'b1;
            err <= 1'b1;
        end else if ((state == S_DATA) && slot_end && !rx_mode && slot_nack) begin
            data_nack <= 1'b1;
            err <= 1'b1;
        end
    end

    // Done pulse: byte held, STOP sent or arbitration abort
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_done <= 1'b0;
        end else begin
            op_done <= arb_hit || ((state == S_DATA) && (next_state == S_HOLD))
                || ((state == S_STOP) && qend);
        end
    end

    // ==========================================
    // Read side
    assign status = {line_busy, (state == S_IDLE), arb_lost, data_nack,
        addr_nack, err, active};
    // Upper bits and unmapped offsets read zero
    assign rd_val = (reg_addr == OFF_TARGET) ? {24'h000000, target}
        : (reg_addr == OFF_CMDSTAT) ? {25'h0000000, status}
        : (reg_addr == OFF_DATA) ? {24'h000000, data_reg}
        : 32'h00000000;

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else begin
            reg_rdata <= reg_rd ? rd_val : 32'h00000000;
        end
    end

    // ==========================================
    // Assertions
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_idle_bit:
    assert property (reg_rd && reg_addr == OFF_CMDSTAT |=> reg_rdata[5] == $past(state == S_IDLE))
        else $error("idle bit does not follow state");
    a_busy_bit:
    assert property (reg_rd && reg_addr == OFF_CMDSTAT |=> reg_rdata[0] == $past(active))
        else $error("busy bit does not follow operation");
    a_line_bit:
    assert property (reg_rd && reg_addr == OFF_CMDSTAT |=> reg_rdata[6] == $past(line_busy))
        else $error("bus busy bit wrong");
    a_error_sum:
    assert property (err == (arb_lost || addr_nack || data_nack))
        else $error("error flag differs from its causes");
    a_arb_abort:
    assert property (arb_hit |=> arb_lost && state == S_IDLE ##1 !sda_oe && !scl_oe)
        else $error("lost arbitration not released");
    a_addr_nack:
    assert property (state == S_ADDR && slot_end && slot_nack |=> addr_nack && state == S_STOP)
        else $error("address nack not handled");
    a_data_nack:
    assert property (state == S_DATA && slot_end && !rx_mode |=> data_nack == $past(slot_nack))
        else $error("data nack flag wrong");
    a_ack_drive:
    assert property (state == S_DATA && rx_mode && last_bit && qtr == 2'h2 |-> sda_oe == ack_req)
        else $error("acknowledge drive wrong");
    a_stop_end:
    assert property (state == S_STOP && qend |=> state == S_IDLE && op_done)
        else $error("stop did not end in idle");
    a_start_go:
    assert property (go |=> state == S_START ##1 !scl_oe)
        else $error("accepted command did not start");
    a_nop_cmd:
    assert property (cmd_wr && state == S_IDLE && act == ACT_NOP |=> state == S_IDLE)
        else $error("ignored command changed state");
    a_done_pulse:
    assert property (op_done |=> !op_done)
        else $error("done longer than one cycle");

    c_send: cover property (go && !target[0]);
    c_receive: cover property (go && target[0]);
    c_arb: cover property (arb_hit);
    c_hold: cover property (state == S_DATA && next_state == S_HOLD);
endmodule
`default_nettype wire

// ===== hw/imc_pkg.sv
// Package: register map, fields, types and timing of the I2C master controller
package imc_pkg;
    // ==========================================
    // Register byte offsets
    localparam logic [7:0] OFF_TARGET = 8'h00;
    localparam logic [7:0] OFF_CMDSTAT = 8'h04;
    localparam logic [7:0] OFF_DATA = 8'h08;
    // ==========================================
    // Values after reset
    localparam logic [7:0] RST_TARGET = 8'h00;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [1:0] RST_SYNC = 2'h3;
    // ==========================================
    // Slot layout: eight data bits then the acknowledge bit
    localparam logic [3:0] SLOT_LAST = 4'h8;
    // Quarter of an SCL bit time at 100 kbit/s
    localparam int CLK_PERIOD_NS = 4;
    localparam int QTR_TIME_NS = 2500;
    localparam int QTR_CYCLES = QTR_TIME_NS / CLK_PERIOD_NS;
    // ==========================================
    // Controller states
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_START = 3'h1,
        S_ADDR = 3'h2,
        S_DATA = 3'h3,
        S_HOLD = 3'h4,
        S_STOP = 3'h5
    } imc_state_t;
    // Decoded command actions
    typedef enum logic [2:0] {
        ACT_NOP = 3'h0,
        ACT_TX = 3'h1,
        ACT_TX_STOP = 3'h2,
        ACT_RX = 3'h3,
        ACT_RX_STOP = 3'h4
    } imc_action_t;
    // Command field, bits 3..0
    typedef struct packed {
        logic ack;
        logic stop;
        logic start;
        logic run;
    } imc_cmd_t;
    // Status field, bits 6..0
    typedef struct packed {
        logic line_occupied;
        logic idle;
        logic arbitration_lost;
        logic data_not_acked;
        logic address_not_acked;
        logic error;
        logic busy;
    } imc_status_t;
endpackage

// ===== hw/imc_line_mon.sv
// Bus line synchroniser and START/STOP watcher
`timescale 1ns/1ps
`default_nettype none
module imc_line_mon
    import imc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Raw bus lines
    input wire logic scl_in,
    input wire logic sda_in,
    // Synchronised lines and bus state
    output logic scl_s,
    output logic sda_s,
    output logic line_busy
);
    // ==========================================
    // Synchronisers
    logic [1:0] scl_sync; // Two-stage SCL
    logic [1:0] sda_sync; // Two-stage SDA
    logic sda_d; // SDA one cycle older
    logic start_seen; // SDA falls, SCL high
    logic stop_seen; // SDA rises, SCL high

    // Lines idle high, so they reset high
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync <= RST_SYNC;
            sda_sync <= RST_SYNC;
            sda_d <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            sda_d <= sda_sync[1];
        end
    end

    assign scl_s = scl_sync[1];
    assign sda_s = sda_sync[1];
    // ==========================================
    // Bus condition detection
    assign start_seen = scl_sync[1] && sda_d && !sda_sync[1];
    assign stop_seen = scl_sync[1] && !sda_d && sda_sync[1];

    // Busy from any START to the next STOP, whoever drives them
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_busy <= 1'b0;
        end else if (start_seen) begin
            line_busy <= 1'b1;
        end else if (stop_seen) begin
            line_busy <= 1'b0;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_line_start:
    assert property (start_seen |=> line_busy)
        else $error("bus busy not set after START");
    a_line_stop:
    assert property (stop_seen |=> !line_busy)
        else $error("bus busy not cleared after STOP");
endmodule
`default_nettype wire

// ===== verification/imc_slave_model.sv
// Behavioural I2C target on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module imc_slave_model #(
    parameter logic [6:0] SLV_ADDR = 7'h3b
) (
    // Bus wires
    input wire logic scl,
    input wire logic sda,
    // Behaviour controls
    input wire logic [7:0] tx_byte,
    input wire logic nack_data,
    input wire logic fight,
    // Pull on the data wire
    output logic sda_pull
);
    // ==========================================
    // Framing state
    logic [7:0] sr = 8'h00;
    logic [7:0] rx_data = 8'h00;
    logic [3:0] bit_cnt = 4'h0;
    logic [1:0] byte_cnt = 2'h0;
    logic sel = 1'b0, rd_mode = 1'b0, last_ack = 1'b0, pull = 1'b0, fwin = 1'b0;
    wire logic hit = (sr[7:1] == SLV_ADDR);
    // START restarts the framing
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            bit_cnt = 4'h0;
            byte_cnt = 2'h0;
            sel = 1'b0;
        end
    end
    // Sample on the rising clock line
    always @(posedge scl) begin
        if (bit_cnt < 4'h8) begin
            sr = {sr[6:0], sda};
        end else begin
            last_ack = sda;
            if (byte_cnt == 2'h0) begin
                sel = hit;
                rd_mode = sr[0];
            end else begin
                rx_data = sr;
            end
            byte_cnt = byte_cnt + 2'h1;
        end
        bit_cnt = (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
    end
    // Change data only while the clock line is low
    always @(negedge scl) begin
        pull = 1'b0;
        fwin = 1'b0;
        if (bit_cnt == 4'h8) begin
            pull = (byte_cnt == 2'h0) ? hit : (sel && !rd_mode && !nack_data);
        end else if (sel && byte_cnt == 2'h1) begin
            pull = rd_mode & ~tx_byte[3'h7 - bit_cnt[2:0]];
            fwin = ~rd_mode;
        end
    end
    // A rival master pulls during data bits only when asked
    assign sda_pull = pull | (fight & fwin);
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench of the I2C master command and status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import imc_pkg::*;
    // ==========================================
    // Signals
    logic ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, tx_byte = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic scl_oe, sda_oe, op_done, slv_pull;
    logic scl_out, sda_out; // Output levels, always low
    logic nack_data = 1'b0, fight = 1'b0;
    int n_errors = 0, tests_run = 0;
    // Open-drain wires with pull-ups
    wire logic scl = ~scl_oe;
    wire logic sda = ~(sda_oe | slv_pull);
    imc_master #(.QTR_CYC(8)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .op_done(op_done));
    imc_slave_model SLV (.scl(scl), .sda(sda), .tx_byte(tx_byte), .nack_data(nack_data),
        .fight(fight), .sda_pull(slv_pull));
    // Clock at 250 MHz
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    // ==========================================
    // Tasks
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hffffffff);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), e, reg_rdata & m);
    endtask
    // Bounded wait for the completion pulse
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (op_done !== 1'b1 && n < 3000);
        chk("op_done", 32'h1, {31'h0, op_done});
        chk("line out levels", 32'h0, {30'h0, scl_out, sda_out});
    endtask
    task automatic run(input logic [31:0] t, input logic [31:0] c, input logic [31:0] st);
        wr(OFF_TARGET, t);
        wr(OFF_CMDSTAT, c);
        wait_done();
        rd(OFF_CMDSTAT, st);
    endtask
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        repeat (40000) @(posedge ref_clk);
        n_errors++;
        give_verdict();
    end
    // ==========================================
    // Test sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(OFF_CMDSTAT, 32'h20);
        wr(8'h0c, 32'hff);
        rd(8'h0c, 32'h0);
        // Commands without start and run, plus the illegal one, do nothing
        wr(OFF_TARGET, 32'h77);
        for (int i = 0; i < 16; i++) begin
            if (i[1:0] != 2'b11 || i == 15) begin
                wr(OFF_CMDSTAT, 32'(i));
                rd(OFF_CMDSTAT, 32'h20);
            end
        end
        // Single byte send closed by STOP
        wr(OFF_DATA, 32'ha5);
        wr(OFF_TARGET, 32'h76);
        wr(OFF_CMDSTAT, 32'h7);
        rd(OFF_CMDSTAT, 32'h01, 32'h21);
        wait_done();
        rd(OFF_CMDSTAT, 32'h20);
        chk("target byte", 32'ha5, {24'h0, SLV.rx_data});
        run(32'h76, 32'h3, 32'h40);
        run(32'h76, 32'h4, 32'h20);
        // Receives with and without acknowledge
        tx_byte <= 8'h5a;
        run(32'h77, 32'h3, 32'h40);
        chk("master ack", 32'h1, {31'h0, SLV.last_ack});
        rd(OFF_DATA, 32'h5a);
        run(32'h77, 32'h4, 32'h20);
        tx_byte <= 8'hc3;
        run(32'h77, 32'hb, 32'h40);
        chk("master ack", 32'h0, {31'h0, SLV.last_ack});
        rd(OFF_DATA, 32'hc3);
        run(32'h77, 32'h4, 32'h20);
        tx_byte <= 8'h3c;
        run(32'h77, 32'h7, 32'h20);
        rd(OFF_DATA, 32'h3c);
        // Failures: address refused, data refused, arbitration lost
        run(32'h10, 32'h7, 32'h26);
        nack_data <= 1'b1;
        run(32'h76, 32'h7, 32'h2a);
        nack_data <= 1'b0;
        wr(OFF_DATA, 32'hff);
        fight <= 1'b1;
        run(32'h76, 32'h7, 32'h72);
        fight <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rd(OFF_CMDSTAT, 32'h32);
        run(32'h76, 32'h7, 32'h20);
        give_verdict();
    end
endmodule
`default_nettype wire
